// ### fpx_exc_pkg.sv
// Purpose: shared constants for the floating-point exception unit
// Assumes: 80-bit extended internal format, 2-bit tags per register
// Notes: offsets are byte addresses on the register bus
package fpx_exc_pkg;
  localparam int EXT_W = 80;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_ZERO = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  // status and control bit positions
  localparam int SW_INV = 0;
  localparam int SW_DNM = 1;
  localparam int SW_DVZ = 2;
  localparam int SW_STK = 6;
  localparam int SW_CC0 = 8;
  localparam int SW_CC1 = 9;
  localparam int SW_CC2 = 10;
  localparam int SW_CC3 = 14;
  localparam int CW_INV = 0;
  localparam int CW_DNM = 1;
  localparam int CW_DVZ = 2;
  // register offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_EVENTS = 4'h8;
  localparam logic [15:0] CONTROL_RST = 16'h037f;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // result encodings
  localparam logic [EXT_W-1:0] FP_INDEF = 80'hffff_c000_0000_0000_0000;
  localparam logic [EXT_W-1:0] FP_POS_INF = 80'h7fff_8000_0000_0000_0000;
  localparam logic [EXT_W-1:0] FP_NEG_INF = 80'hffff_8000_0000_0000_0000;
  localparam logic [EXT_W-1:0] INT_INDEF = 80'h0000_0000_0000_8000_0000;
  localparam logic [EXT_W-1:0] BCD_INDEF = 80'hffff_c000_0000_0000_0000;
  localparam logic [EXT_W-1:0] QNAN_BIT = 80'h0000_4000_0000_0000_0000;
  // operation classes offered by the pipeline
  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD_MEM, OP_LOAD_EXT, OP_ADD, OP_SUB, OP_MUL, OP_DIV,
    OP_DIVR, OP_IDIV, OP_COMPARE, OP_COMPARE_FLAGS, OP_UCOMPARE,
    OP_PREM, OP_TRIG, OP_SQRT, OP_LOG2, OP_LOG2P1, OP_XTRACT,
    OP_DEC_STORE, OP_INT_STORE, OP_FP_STORE, OP_EXCHANGE
  } op_t;
  // operand classes
  typedef enum logic [2:0] {
    CL_ZERO, CL_NORMAL, CL_DENORMAL, CL_INF, CL_QNAN, CL_SNAN, CL_UNSUPP
  } class_t;
endpackage

// ### fpx_exc_unit.sv
// Purpose: stack, invalid, denormal and divide-by-zero exception logic
// Assumes: one request per cycle; pipeline supplies operand classes
// Notes: answer appears one cycle after the request
// Notes on behaviour
// - load from memory onto non-empty tag (00,01,10) is stack overflow
// - source register tagged 11 (empty) is stack underflow, stores too
// - stack fault sets invalid flag bit 0 and stack-fault bit 6
// - condition code one bit 9: 1 for overflow, 0 for underflow
// - masked stack fault writes the instruction's indefinite value
// - unmasked fault: set flag, request handler, keep top and sources
// - invalid arithmetic operand sets bit 0; masked gives default result
// - quiet NaN alone is not invalid except ordered compares, masked or not
// - masked unsupported format gives indefinite; signaling NaN gives QNaN
// - masked ordered compare with NaN sets codes or eflags to 111
// - infinity sums, inf times zero, inf/inf, 0/0 give indefinite
// - remainder zero divisor, inf dividend, trig of inf: indefinite, cc two 0
// - sqrt or log of negative (not -0), log-plus-one below -1: indefinite
// - decimal overflow stores decimal indefinite; integer one integer
// - masked exchange with empty registers loads indefinite then swaps
// - denormal on arithmetic or single/double load; not extended load
// - masked denormal sets flag, continues, normalizes the value
// - divide-by-zero for finite non-zero over zero; bits 2 and 2
// - only divides, integer divide, log2 and exponent extract report it
// - masked divide by zero gives infinity with xor of signs
// - log gives inf opposite sign; extract gives -inf and signed zero
// - invalid masked by control bit 0; mask selects masked response
// - stack-fault flag is never cleared by an invalid arithmetic case
`timescale 1ns/10ps
module fpx_exc_unit
  import fpx_exc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request from the pipeline
  input wire logic req_valid,
  input wire op_t req_op,
  input wire logic [1:0] dst_tag,
  input wire logic [1:0] src_a_tag,
  input wire logic [1:0] src_b_tag,
  input wire logic src_b_used,
  input wire class_t src_a_class,
  input wire class_t src_b_class,
  input wire logic src_a_sign,
  input wire logic src_b_sign,
  input wire logic src_a_below_m1,
  input wire logic load_is_short,
  input wire logic range_overflow,
  input wire logic [EXT_W-1:0] src_a_value,
  input wire logic [EXT_W-1:0] src_b_value,
  // answer to the pipeline
  output logic res_valid,
  output logic [EXT_W-1:0] res_value,
  output logic [EXT_W-1:0] res_value_b,
  output logic res_write,
  output logic res_write_b,
  output logic res_normalize,
  output logic res_proceed,
  output logic handler_req,
  output logic keep_state,
  output logic carry_flag,
  output logic parity_flag,
  output logic zero_result_flag,
  output logic eflags_write,
  // register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic is_nan(input class_t c);
    return (c == CL_QNAN) || (c == CL_SNAN);
  endfunction

  function automatic logic is_finite_nz(input class_t c);
    return (c == CL_NORMAL) || (c == CL_DENORMAL);
  endfunction

  logic [15:0] status_r;
  logic [15:0] control_r;
  logic [3:0] events_r;
  logic invalid_op_mask, denormal_mask, divzero_mask;
  assign invalid_op_mask = control_r[CW_INV];
  assign denormal_mask = control_r[CW_DNM];
  assign divzero_mask = control_r[CW_DVZ];

  // detection
  logic is_load, b_src, overflow, underflow, stack_fault_exception;
  logic snan_in, qnan_in, unsupp_in, denorm_in, a_inf, b_inf, a_zero, b_zero;
  logic ordered, invalid_arith_exception, denormal_exc, divzero_exc;
  logic neg_op, xch_empty;
  always_comb begin
    is_load = (req_op == OP_LOAD_MEM) || (req_op == OP_LOAD_EXT);
    b_src = src_b_used && !is_load;
    overflow = is_load && (dst_tag != TAG_EMPTY);
    underflow = !is_load && req_op != OP_NONE &&
      req_op != OP_EXCHANGE &&
      (src_a_tag == TAG_EMPTY || (b_src && src_b_tag == TAG_EMPTY));
    xch_empty = req_op == OP_EXCHANGE &&
      (src_a_tag == TAG_EMPTY || src_b_tag == TAG_EMPTY);
    stack_fault_exception = req_valid && (overflow || underflow || xch_empty);
    snan_in = src_a_class == CL_SNAN || (b_src && src_b_class == CL_SNAN);
    qnan_in = src_a_class == CL_QNAN || (b_src && src_b_class == CL_QNAN);
    unsupp_in = src_a_class == CL_UNSUPP ||
      (b_src && src_b_class == CL_UNSUPP);
    a_inf = src_a_class == CL_INF;
    b_inf = src_b_class == CL_INF;
    a_zero = src_a_class == CL_ZERO;
    b_zero = src_b_class == CL_ZERO;
    ordered = req_op == OP_COMPARE || req_op == OP_COMPARE_FLAGS;
    neg_op = src_a_sign && src_a_class != CL_ZERO && !is_nan(src_a_class);
    invalid_arith_exception = 1'b0;
    if (req_valid && !stack_fault_exception && !is_load &&
        req_op != OP_EXCHANGE && req_op != OP_NONE) begin
      invalid_arith_exception = unsupp_in || snan_in;
      if (ordered && qnan_in)
        invalid_arith_exception = 1'b1;
      unique case (req_op)
        OP_ADD: if (a_inf && b_inf && src_a_sign != src_b_sign)
          invalid_arith_exception = 1'b1;
        OP_SUB: if (a_inf && b_inf && src_a_sign == src_b_sign)
          invalid_arith_exception = 1'b1;
        OP_MUL: if ((a_inf && b_zero) || (a_zero && b_inf))
          invalid_arith_exception = 1'b1;
        OP_DIV, OP_DIVR, OP_IDIV: if ((a_inf && b_inf) || (a_zero && b_zero))
          invalid_arith_exception = 1'b1;
        OP_PREM: if (b_zero || a_inf)
          invalid_arith_exception = 1'b1;
        OP_TRIG: if (a_inf)
          invalid_arith_exception = 1'b1;
        OP_SQRT, OP_LOG2: if (neg_op)
          invalid_arith_exception = 1'b1;
        OP_LOG2P1: if (src_a_below_m1)
          invalid_arith_exception = 1'b1;
        OP_DEC_STORE, OP_INT_STORE: if (range_overflow)
          invalid_arith_exception = 1'b1;
        default: ;
      endcase
    end
    denorm_in = src_a_class == CL_DENORMAL ||
      (b_src && src_b_class == CL_DENORMAL);
    denormal_exc = req_valid && !stack_fault_exception &&
      !invalid_arith_exception && req_op != OP_NONE &&
      req_op != OP_EXCHANGE && req_op != OP_LOAD_EXT &&
      (req_op == OP_LOAD_MEM ? (load_is_short &&
      src_a_class == CL_DENORMAL) : denorm_in);
    divzero_exc = 1'b0;
    if (req_valid && !stack_fault_exception && !invalid_arith_exception &&
        !(denormal_exc && !denormal_mask)) begin
      unique case (req_op)
        OP_DIV, OP_DIVR, OP_IDIV:
          divzero_exc = is_finite_nz(src_a_class) && b_zero;
        OP_LOG2: divzero_exc = a_zero && is_finite_nz(src_b_class);
        OP_XTRACT: divzero_exc = a_zero;
        default: ;
      endcase
    end
  end

  logic unmasked;
  assign unmasked = ((stack_fault_exception || invalid_arith_exception) &&
    !invalid_op_mask) || (denormal_exc && !denormal_mask) ||
    (divzero_exc && !divzero_mask);

  // masked responses
  logic [EXT_W-1:0] val_nxt, val_b_nxt;
  logic wr_nxt, wr_b_nxt, eflags_nxt;
  logic [3:0] cc_nxt, cc_we;
  always_comb begin
    val_nxt = src_a_value;
    val_b_nxt = src_b_value;
    wr_nxt = 1'b0;
    wr_b_nxt = 1'b0;
    eflags_nxt = 1'b0;
    cc_nxt = 4'h0;
    cc_we = 4'h0;
    if (unmasked) begin
      wr_nxt = 1'b0;
    end else if (stack_fault_exception) begin
      wr_nxt = 1'b1;
      unique case (req_op)
        OP_DEC_STORE: val_nxt = BCD_INDEF;
        OP_INT_STORE: val_nxt = INT_INDEF;
        OP_EXCHANGE: begin
          val_nxt = src_b_tag == TAG_EMPTY ? FP_INDEF : src_b_value;
          val_b_nxt = src_a_tag == TAG_EMPTY ? FP_INDEF : src_a_value;
          wr_b_nxt = 1'b1;
        end
        default: val_nxt = FP_INDEF;
      endcase
    end else if (invalid_arith_exception) begin
      wr_nxt = 1'b1;
      val_nxt = FP_INDEF;
      if (ordered && (qnan_in || snan_in || (is_nan(src_a_class) ||
          is_nan(src_b_class)))) begin
        wr_nxt = 1'b0;
        if (req_op == OP_COMPARE_FLAGS) begin
          eflags_nxt = 1'b1;
        end else begin
          cc_nxt = 4'hd;
          cc_we = 4'hd;
        end
      end else if (req_op == OP_PREM || req_op == OP_TRIG) begin
        cc_nxt = 4'h0;
        cc_we = 4'h4;
      end else if (req_op == OP_DEC_STORE) begin
        val_nxt = BCD_INDEF;
      end else if (req_op == OP_INT_STORE) begin
        val_nxt = INT_INDEF;
      end else if (!unsupp_in && snan_in) begin
        val_nxt = (src_a_class == CL_SNAN ? src_a_value : src_b_value) |
          QNAN_BIT;
      end
    end else if (divzero_exc) begin
      wr_nxt = 1'b1;
      unique case (req_op)
        OP_LOG2: val_nxt = src_b_sign ? FP_POS_INF : FP_NEG_INF;
        OP_XTRACT: begin
          val_b_nxt = FP_NEG_INF;
          val_nxt = {src_a_sign, {(EXT_W-1){1'b0}}};
          wr_b_nxt = 1'b1;
        end
        default: val_nxt = (src_a_sign ^ src_b_sign) ?
          FP_NEG_INF : FP_POS_INF;
      endcase
    end
  end

  // answer register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      res_valid <= 1'b0;
      res_value <= '0;
      res_value_b <= '0;
      res_write <= 1'b0;
      res_write_b <= 1'b0;
      res_normalize <= 1'b0;
      res_proceed <= 1'b0;
      handler_req <= 1'b0;
      keep_state <= 1'b0;
      carry_flag <= 1'b0;
      parity_flag <= 1'b0;
      zero_result_flag <= 1'b0;
      eflags_write <= 1'b0;
    end else begin
      res_valid <= req_valid;
      res_value <= val_nxt;
      res_value_b <= val_b_nxt;
      res_write <= req_valid && wr_nxt;
      res_write_b <= req_valid && wr_b_nxt;
      res_normalize <= denormal_exc && denormal_mask;
      res_proceed <= req_valid && !unmasked &&
        !stack_fault_exception && !invalid_arith_exception &&
        !divzero_exc;
      handler_req <= req_valid && unmasked;
      keep_state <= req_valid && unmasked;
      carry_flag <= eflags_nxt;
      parity_flag <= eflags_nxt;
      zero_result_flag <= eflags_nxt;
      eflags_write <= req_valid && eflags_nxt;
    end
  end

  // bus write decode
  logic wr_fire, rd_fire, status_wr, control_wr;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_fire = s_axi_awready;
  assign status_wr = wr_fire && s_axi_awaddr == OFS_STATUS;
  assign control_wr = wr_fire && s_axi_awaddr == OFS_CONTROL;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // status word: hardware sets win over software writes
  logic [15:0] sw_base, set_bits;
  always_comb begin
    sw_base = status_r;
    if (status_wr) begin
      if (s_axi_wstrb[0]) sw_base[7:0] = s_axi_wdata[7:0];
      if (s_axi_wstrb[1]) sw_base[15:8] = s_axi_wdata[15:8];
    end
    set_bits = 16'h0;
    if (stack_fault_exception || invalid_arith_exception)
      set_bits[SW_INV] = 1'b1;
    if (stack_fault_exception) set_bits[SW_STK] = 1'b1;
    if (denormal_exc) set_bits[SW_DNM] = 1'b1;
    if (divzero_exc) set_bits[SW_DVZ] = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= sw_base | set_bits;
      if (stack_fault_exception)
        status_r[SW_CC1] <= overflow;
      else if (req_valid) begin
        if (cc_we[0]) status_r[SW_CC0] <= cc_nxt[0];
        if (cc_we[2]) status_r[SW_CC2] <= cc_nxt[2];
        if (cc_we[3]) status_r[SW_CC3] <= cc_nxt[3];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      control_r <= CONTROL_RST;
    end else if (control_wr) begin
      if (s_axi_wstrb[0]) control_r[7:0] <= s_axi_wdata[7:0];
      if (s_axi_wstrb[1]) control_r[15:8] <= s_axi_wdata[15:8];
    end
  end

  // last event kinds seen, for software
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      events_r <= 4'h0;
    end else if (req_valid) begin
      events_r <= {divzero_exc, denormal_exc, invalid_arith_exception,
        stack_fault_exception};
    end
  end

  // bus responses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (status_wr || control_wr) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        OFS_STATUS: s_axi_rdata <= {16'h0, status_r};
        OFS_CONTROL: s_axi_rdata <= {16'h0, control_r};
        OFS_EVENTS: s_axi_rdata <= {28'h0, events_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_overflow_cc1: assert property (@(posedge core_clk) disable iff (sys_rst)
    req_valid && overflow |=> status_r[SW_CC1] && status_r[SW_STK])
    else $error("overflow did not set cc1 and stack fault");
  a_underflow_cc1: assert property (@(posedge core_clk) disable iff (sys_rst)
    req_valid && underflow |=> !status_r[SW_CC1] && status_r[SW_INV])
    else $error("underflow left cc1 set or invalid clear");
  a_unmasked_nowrite: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    handler_req |-> !res_write && !res_write_b && keep_state)
    else $error("handler request with a write");
  a_sf_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
    status_r[SW_STK] && !status_wr |=> status_r[SW_STK])
    else $error("stack fault flag dropped");
  a_divzero_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    divzero_exc |=> status_r[SW_DVZ])
    else $error("divide by zero flag not set");
  a_denorm_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    denormal_exc |=> status_r[SW_DNM])
    else $error("denormal flag not set");
  a_ext_load_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    req_op == OP_LOAD_EXT |-> !denormal_exc)
    else $error("denormal on extended load");
  a_divzero_ops: assert property (@(posedge core_clk) disable iff (sys_rst)
    divzero_exc |-> req_op inside {OP_DIV, OP_DIVR, OP_IDIV, OP_LOG2,
    OP_XTRACT})
    else $error("divide by zero from wrong op");
  a_masked_sf_write: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    stack_fault_exception && invalid_op_mask |=> res_write)
    else $error("masked stack fault wrote nothing");
endmodule

// ### fpx_pipe_model.sv
// Purpose: pipeline-side model that issues requests to the exception unit
// Assumes: caller picks the idle gap; one request per call
// Notes: operand values are scrambled once a request has been taken
`timescale 1ns/10ps
module fpx_pipe_model
  import fpx_exc_pkg::*;
(
  // clock
  input wire logic core_clk,
  // request to the exception unit
  output logic req_valid,
  output op_t req_op,
  output logic [1:0] dst_tag,
  output logic [1:0] src_a_tag,
  output logic [1:0] src_b_tag,
  output logic src_b_used,
  output class_t src_a_class,
  output class_t src_b_class,
  output logic src_a_sign,
  output logic src_b_sign,
  output logic src_a_below_m1,
  output logic load_is_short,
  output logic range_overflow,
  output logic [EXT_W-1:0] src_a_value,
  output logic [EXT_W-1:0] src_b_value
);
  initial begin
    req_valid = 1'b0;
    req_op = OP_NONE;
    src_a_class = CL_ZERO;
    src_b_class = CL_ZERO;
    {dst_tag, src_a_tag, src_b_tag, src_b_used} = 7'h7f;
    {src_a_sign, src_b_sign, src_a_below_m1, load_is_short,
      range_overflow} = 5'h00;
    {src_a_value, src_b_value} = '0;
  end

  // bits: sign a, sign b, below minus one, short load, range overflow
  task automatic send(input int gap, input op_t o, input logic [1:0] d,
      input logic [1:0] ta, input logic [1:0] tb, input logic u,
      input class_t ca, input class_t cb, input logic [4:0] bits,
      input logic [EXT_W-1:0] va, input logic [EXT_W-1:0] vb);
    repeat (gap) @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= o;
    src_a_class <= ca;
    src_b_class <= cb;
    {dst_tag, src_a_tag, src_b_tag, src_b_used} <= {d, ta, tb, u};
    {src_a_sign, src_b_sign, src_a_below_m1, load_is_short,
      range_overflow} <= bits;
    {src_a_value, src_b_value} <= {va, vb};
    @(posedge core_clk);
    req_valid <= 1'b0;
    // taken values no longer stand on the bus
    {src_a_value, src_b_value} <= ~{va, vb};
  endtask
endmodule

// ### test_fpx_exc_unit.sv
// Purpose: self-checking bench for the floating-point exception unit
// Assumes: registers over AXI4-Lite, pipeline model drives the requests
// Notes: expectations come from a behavioural model of the unit
`timescale 1ns/10ps
module test_fpx_exc_unit
  import fpx_exc_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid, src_b_used, src_a_sign, src_b_sign, src_a_below_m1;
  logic load_is_short, range_overflow, res_valid, res_write, res_write_b;
  logic res_normalize, res_proceed, handler_req, keep_state, carry_flag;
  logic parity_flag, zero_result_flag, eflags_write;
  op_t req_op, op;
  logic [1:0] dst_tag, src_a_tag, src_b_tag, dt, ta, tg;
  class_t src_a_class, src_b_class, ca, cb;
  logic [EXT_W-1:0] src_a_value, src_b_value, res_value, res_value_b, va, vb;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h3;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0001_5eeb;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ub, sa, sb, bl, sh, ro, keep;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] sw, cw;
  int mismatches = 0;
  int n_checks = 0;

  always #2 core_clk = ~core_clk;

  // every port meets the bench signal of the same name
  fpx_pipe_model fpx_pipe_model_inst (.*);
  fpx_exc_unit fpx_exc_unit_inst (.*);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic fail_to(input string nm);
    mismatches++;
    $display("[FAIL] %s expected answer seen none", nm);
    test_done();
  endtask

  task automatic chkv(input string nm, input logic [79:0] e,
      input logic [79:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    chkv(nm, {79'h0, e}, {79'h0, g});
  endtask

  task automatic chkr(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    chkv(nm, {48'h0, e}, {48'h0, g});
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
        return;
      end
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    fail_to("axi write");
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
      input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_rvalid && s_axi_rready) begin
        chkr("rdata", e, s_axi_rdata & m);
        chkr("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
        return;
      end
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    fail_to("axi read");
  endtask

  task automatic clr();
    {dt, ta, tg, ub, sa, sb, bl, sh, ro, keep} = {TAG_EMPTY, 4'h0, 7'h40};
    va = EXT_W'({xs(), xs(), xs()});
    vb = EXT_W'({xs(), xs(), xs()});
  endtask

  // model of the unit: stack > invalid > denormal > divide by zero
  task automatic go(input op_t o, input class_t a, input class_t b,
      input logic [1:0] s);
    logic so, su, st, sn, ia, de, dz, hq, wr, wb, cmp;
    logic [79:0] ev, evb;
    {op, ca, cb, sa, sb} = {o, a, b, s};
    ub = ub && !(o inside {OP_LOAD_MEM, OP_LOAD_EXT, OP_INT_STORE,
      OP_DEC_STORE, OP_SQRT, OP_TRIG, OP_XTRACT});
    if (!keep) axi_wr(OFS_STATUS, 32'h0, rr);
    if (!keep) sw = 16'h0000;
    so = op inside {OP_LOAD_MEM, OP_LOAD_EXT} && dt != TAG_EMPTY;
    su = !(op inside {OP_LOAD_MEM, OP_LOAD_EXT}) &&
      (ta == TAG_EMPTY || ub && tg == TAG_EMPTY);
    st = so || su;
    sn = ca == CL_SNAN || ub && cb == CL_SNAN;
    cmp = op inside {OP_COMPARE, OP_COMPARE_FLAGS};
    case (op)
      OP_ADD: ia = ca == CL_INF && cb == CL_INF && sa != sb;
      OP_SUB: ia = ca == CL_INF && cb == CL_INF && sa == sb;
      OP_MUL: ia = ca == CL_INF && cb == CL_ZERO ||
        ca == CL_ZERO && cb == CL_INF;
      OP_DIV, OP_DIVR, OP_IDIV: ia = ca == cb && ca inside {CL_ZERO, CL_INF};
      OP_PREM: ia = cb == CL_ZERO || ca == CL_INF;
      OP_TRIG: ia = ca == CL_INF;
      OP_SQRT, OP_LOG2: ia = sa && ca == CL_NORMAL;
      OP_LOG2P1: ia = bl;
      OP_INT_STORE, OP_DEC_STORE: ia = ro;
      default: ia = cmp && (ca inside {CL_QNAN, CL_SNAN} ||
        ub && cb inside {CL_QNAN, CL_SNAN});
    endcase
    ia = ia || sn || ca == CL_UNSUPP;
    de = ca == CL_DENORMAL && (op == OP_LOAD_MEM ? sh : op != OP_LOAD_EXT);
    dz = op inside {OP_DIV, OP_DIVR, OP_IDIV} && cb == CL_ZERO &&
      ca == CL_NORMAL || op == OP_LOG2 && ca == CL_ZERO &&
      cb == CL_NORMAL || op == OP_XTRACT && ca == CL_ZERO;
    {hq, wr, wb, ev, evb} = {3'h0, FP_INDEF, FP_INDEF};
    if (st || ia) begin
      sw[SW_INV] = 1'b1;
      hq = !cw[CW_INV];
      wr = !hq && !cmp;
      if (op == OP_INT_STORE) ev = INT_INDEF;
      if (op == OP_DEC_STORE) ev = BCD_INDEF;
      if (!st && sn) ev = va | QNAN_BIT;
      if (!hq && op == OP_COMPARE) sw = sw | 16'h4500;
      if (st) sw = sw | {6'h0, so, 2'h0, 1'b1, 6'h01};
      if (op == OP_EXCHANGE) ev = tg == TAG_EMPTY ? FP_INDEF : vb;
      if (op == OP_EXCHANGE) evb = ta == TAG_EMPTY ? FP_INDEF : va;
      wb = wr && op == OP_EXCHANGE;
    end else if (de) begin
      sw[SW_DNM] = 1'b1;
      hq = !cw[CW_DNM];
    end else if (dz) begin
      sw[SW_DVZ] = 1'b1;
      hq = !cw[CW_DVZ];
      wr = !hq;
      ev = (sa ^ sb) ? FP_NEG_INF : FP_POS_INF;
      if (op == OP_LOG2) ev = sb ? FP_POS_INF : FP_NEG_INF;
      if (op == OP_XTRACT) ev = {sa, 79'h0};
      evb = FP_NEG_INF;
      wb = wr && op == OP_XTRACT;
    end
    fpx_pipe_model_inst.send(int'(xs() % 32'h3), op, dt, ta, tg, ub, ca, cb,
      {sa, sb, bl, sh, ro}, va, vb);
    #1;
    if (res_valid !== 1'b1) fail_to("res_valid");
    chkb("handler_req", hq, handler_req);
    chkb("keep_state", hq, keep_state);
    if (st || ia || dz) chkb("res_write", wr, res_write);
    if (wr) chkv("res_value", ev, res_value);
    if (wb) chkv("res_value_b", evb, res_value_b);
    if (de && !st && !ia) chkb("normalize", !hq, res_normalize);
    if (!(st || ia || de || dz)) chkb("proceed", 1'b1, res_proceed);
    if (op == OP_COMPARE_FLAGS) chkb("eflags", !hq && ia, eflags_write &&
      carry_flag && parity_flag && zero_result_flag);
    rdchk(OFS_STATUS, 32'h4747, {16'h0, sw & 16'h4747}, 2'h0);
    $display("test %s done", op.name());
    clr();
  endtask

  initial begin
    cw = CONTROL_RST;
    clr();
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(OFS_STATUS, 32'hffff, 32'h0, 2'h0);
    rdchk(OFS_CONTROL, 32'hffff, 32'h37f, 2'h0);
    rdchk(4'hc, 32'hffff_ffff, 32'h0, 2'h2);
    axi_wr(4'hc, 32'h0, rr);
    chkr("bresp", 32'h2, {30'h0, rr});
    for (int t = 0; t < 4; t++) begin
      dt = t[1:0];
      go(OP_LOAD_MEM, CL_NORMAL, CL_NORMAL, 2'h0);
    end
    for (int k = 0; k < 3; k++) begin
      ta = TAG_EMPTY;
      go(k == 0 ? OP_ADD : k == 1 ? OP_INT_STORE : OP_DEC_STORE, CL_NORMAL,
        CL_NORMAL, 2'h0);
    end
    keep = 1'b1;
    go(OP_ADD, CL_INF, CL_INF, 2'h1);
    go(OP_SUB, CL_INF, CL_INF, 2'h3);
    go(OP_MUL, CL_ZERO, CL_INF, 2'h0);
    go(OP_DIV, CL_ZERO, CL_ZERO, 2'h2);
    go(OP_DIV, CL_INF, CL_INF, 2'h0);
    go(OP_PREM, CL_NORMAL, CL_ZERO, 2'h0);
    go(OP_TRIG, CL_INF, CL_NORMAL, 2'h0);
    go(OP_SQRT, CL_NORMAL, CL_NORMAL, 2'h2);
    go(OP_SQRT, CL_ZERO, CL_NORMAL, 2'h2);
    go(OP_LOG2, CL_NORMAL, CL_NORMAL, 2'h2);
    bl = 1'b1;
    go(OP_LOG2P1, CL_NORMAL, CL_NORMAL, 2'h2);
    ro = 1'b1;
    go(OP_INT_STORE, CL_NORMAL, CL_NORMAL, 2'h0);
    ro = 1'b1;
    go(OP_DEC_STORE, CL_NORMAL, CL_NORMAL, 2'h0);
    go(OP_ADD, CL_SNAN, CL_NORMAL, 2'h0);
    go(OP_ADD, CL_UNSUPP, CL_NORMAL, 2'h0);
    go(OP_COMPARE, CL_QNAN, CL_NORMAL, 2'h0);
    go(OP_COMPARE_FLAGS, CL_NORMAL, CL_QNAN, 2'h0);
    ta = TAG_EMPTY;
    go(OP_EXCHANGE, CL_NORMAL, CL_NORMAL, 2'h0);
    go(OP_ADD, CL_DENORMAL, CL_NORMAL, 2'h0);
    sh = 1'b1;
    go(OP_LOAD_MEM, CL_DENORMAL, CL_NORMAL, 2'h0);
    go(OP_LOAD_EXT, CL_DENORMAL, CL_NORMAL, 2'h0);
    for (int s = 0; s < 4; s++)
      go(OP_DIV, CL_NORMAL, CL_ZERO, s[1:0]);
    go(OP_DIVR, CL_NORMAL, CL_ZERO, 2'h1);
    go(OP_IDIV, CL_NORMAL, CL_ZERO, 2'h2);
    go(OP_MUL, CL_NORMAL, CL_ZERO, 2'h1);
    go(OP_LOG2, CL_ZERO, CL_NORMAL, 2'h1);
    go(OP_XTRACT, CL_ZERO, CL_NORMAL, 2'h2);
    axi_wr(OFS_CONTROL, 32'h0000_0378, rr);
    cw = 16'h0378;
    ta = TAG_EMPTY;
    go(OP_ADD, CL_NORMAL, CL_NORMAL, 2'h0);
    go(OP_ADD, CL_QNAN, CL_NORMAL, 2'h0);
    go(OP_COMPARE, CL_QNAN, CL_NORMAL, 2'h0);
    go(OP_DIV, CL_NORMAL, CL_ZERO, 2'h0);
    go(OP_ADD, CL_DENORMAL, CL_NORMAL, 2'h0);
    test_done();
  end
endmodule
